// ---- cstw_map.svh ----
// Offsets, field positions, window bounds and size codes of the cache SRAM test window
`ifndef CSTW_MAP_SVH
`define CSTW_MAP_SVH

// Configuration port pair select
`define CSTW_PORT_INDEX 1'b0
`define CSTW_PORT_DATA 1'b1

// Configuration indexes
`define CSTW_IDX_TIMING 8'h20
`define CSTW_IDX_CACHE 8'h21
`define CSTW_IDX_TEST 8'h22
`define CSTW_IDX_HOLD_LO 8'h23
`define CSTW_IDX_HOLD_HI 8'h24

// Field positions
`define CSTW_BIT_TAGWR_SLOW 0
`define CSTW_BIT_DATA_TEST 0
`define CSTW_BIT_TAG_TEST 1
`define CSTW_BIT_WIN_HIGH 3
`define CSTW_BIT_DUAL_BANK 3
`define CSTW_FLD_SIZE_HI 2
`define CSTW_FLD_SIZE_LO 0

// Cache size codes
`define CSTW_SIZE_64K 3'h0
`define CSTW_SIZE_128K 3'h1
`define CSTW_SIZE_256K 3'h2
`define CSTW_SIZE_512K 3'h3
`define CSTW_SIZE_1M 3'h4

// Window bounds, byte addresses
`define CSTW_WIN_LO_BASE 32'h0004_0000
`define CSTW_WIN_LO_TOP 32'h0007_FFFF
`define CSTW_WIN_LO512_BASE 32'h0002_0000
`define CSTW_WIN_LO512_TOP 32'h0009_FFFF
`define CSTW_WIN_HI_BASE 32'h0010_0000
`define CSTW_WIN_HI_TOP 32'h0017_FFFF
`define CSTW_REMAP_BASE 32'h0008_0000
`define CSTW_REMAP_BIT 19

// Lowest address bit that feeds the cache line address in dual bank mode
`define CSTW_CA2_BASE_BIT 5'h10

// Wait states of tag cycles
`define CSTW_WS_ZERO 2'h0
`define CSTW_WS_TAGWR_FAST 2'h1
`define CSTW_WS_TAGWR_SLOW 2'h2

// Reset values
`define CSTW_RST_BYTE 8'h00
`define CSTW_RST_SIZE 3'h0

`endif

// ---- cstw_pkg.sv ----
// Types of the cache SRAM test window block
`default_nettype none
package cstw_pkg;

    // Bus cycle sequencer states
    typedef enum logic [1:0] {
        CSTW_IDLE = 2'b00,
        CSTW_ACCESS = 2'b01
    } cstw_state_e;

    // Complete state of the top module
    typedef struct packed {
        cstw_state_e st;
        logic [1:0] waitCnt;
        logic tagRead;
        logic [7:0] idx;
        logic tagWrSlow;
        logic [2:0] cacheSize;
        logic dualBank;
        logic winHigh;
        logic dataTest;
        logic tagTest;
        logic [7:0] holdWrLo;
        logic [7:0] holdWrHi;
        logic [7:0] holdRdLo;
        logic [7:0] holdRdHi;
        logic [7:0] cfgRdata;
        logic rdyN;
        logic forceHit;
        logic dramWrBlock;
        logic uncache;
        logic testActive;
        logic [19:2] sramAddr;
        logic ca2;
        logic dataCsN;
        logic dataWeN;
        logic [1:0] bankEnN;
        logic tagWeN;
        logic kenN;
    } cstw_state_s;

endpackage
`default_nettype wire

// ---- cstw_tag_sram_model.sv ----
// Behavioural model of the external tag SRAM
`default_nettype none
module cstw_tag_sram_model (
    input wire logic ref_clk,
    input wire logic [19:4] tagAddr,
    input wire logic [15:0] tagWdata,
    input wire logic tagWeN,
    output logic [15:0] tagRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Only 256 lines are kept; higher lines alias, enough for short tests
    logic [15:0] mem [256];
    // Pattern content, so an unwritten line never reads as a held value
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 16'h5A5A ^ 16'(i);
    end
    // Active low write strobe sampled at the clock edge
    always @(posedge ref_clk) begin
        if (tagWeN === 1'b0) mem[tagAddr[11:4]] <= tagWdata;
    end
    // Read data follows the address, as an asynchronous part would
    assign tagRdata = mem[tagAddr[11:4]];
endmodule // cstw_tag_sram_model
`default_nettype wire

// ---- cstw_test_window.sv ----
// Cache data and tag SRAM test window logic of the secondary cache controller
`default_nettype none
`include "cstw_map.svh"

module cstw_test_window (
    input wire logic ref_clk,
    input wire logic rstn,
    // Processor local bus
    input wire logic adsN,
    input wire logic [31:2] cpuAddr,
    input wire logic cpuWrite,
    input wire logic cpuMem,
    output logic rdyN,
    output logic brdyN,
    // Normal cache-enable decision and programmed hit timing from the cache core
    input wire logic kenNormalN,
    input wire logic [1:0] readHitWs,
    input wire logic [1:0] writeDirtyWs,
    output logic kenN,
    // Indexed configuration port pair
    input wire logic cfgWr,
    input wire logic cfgRd,
    input wire logic cfgPort,
    input wire logic [7:0] cfgWdata,
    output logic [7:0] cfgRdata,
    // DRAM controller side
    output logic forceHit,
    output logic dramWrBlock,
    output logic cycUncacheable,
    output logic fillInhibit,
    output logic castoutInhibit,
    output logic tagUpdInhibit,
    // Cache data SRAMs
    output logic [19:2] sramAddr,
    output logic cache_line_addr_bit2,
    output logic dataCsN,
    output logic dataWeN,
    output logic [1:0] bankEnN,
    // Tag SRAM
    output logic [19:4] tagAddr,
    input wire logic [15:0] tagRdata,
    output logic [15:0] tagWdata,
    output logic tagWeN
);

    cstw_pkg::cstw_state_s s_r; // Registered state
    cstw_pkg::cstw_state_s s_nxt; // Next state

    logic winHit; // Current address lies in the test window
    logic [19:2] winSram; // Remapped SRAM address for the current address
    logic busStart; // Memory cycle starts this edge
    logic [4:0] ca2Sel; // Address bit routed to the line address pin

    // Window decode and low-window remap
    cstw_window_dec u_dec (
        .cpuAddr(cpuAddr),
        .winHigh(s_r.winHigh),
        .cacheSize(s_r.cacheSize),
        .inWindow(winHit),
        .sramAddr(winSram)
    );

    // Only memory cycles are looked at; the sequencer ignores a new start while busy
    assign busStart = !adsN && cpuMem && (s_r.st == cstw_pkg::CSTW_IDLE);

    // Dual bank line address bit follows the programmed size
    assign ca2Sel = `CSTW_CA2_BASE_BIT + {2'h0, s_r.cacheSize};

    // Next state
    always_comb begin
        s_nxt = s_r;
        // One-cycle outputs fall back to idle levels by default
        s_nxt.rdyN = 1'b1;
        s_nxt.tagWeN = 1'b1;
        s_nxt.testActive = s_r.dataTest || s_r.tagTest;

        // Cache-enable decision passes through untouched by either mode
        s_nxt.kenN = kenNormalN;

        // Configuration port pair: index port then data port
        if (cfgWr) begin
            if (cfgPort == `CSTW_PORT_INDEX) begin
                s_nxt.idx = cfgWdata;
            end else begin
                unique case (s_r.idx)
                    `CSTW_IDX_TIMING: begin
                        s_nxt.tagWrSlow = cfgWdata[`CSTW_BIT_TAGWR_SLOW];
                    end
                    `CSTW_IDX_CACHE: begin
                        s_nxt.cacheSize = cfgWdata[`CSTW_FLD_SIZE_HI:`CSTW_FLD_SIZE_LO];
                        s_nxt.dualBank = cfgWdata[`CSTW_BIT_DUAL_BANK];
                    end
                    `CSTW_IDX_TEST: begin
                        s_nxt.winHigh = cfgWdata[`CSTW_BIT_WIN_HIGH];
                        s_nxt.dataTest = cfgWdata[`CSTW_BIT_DATA_TEST];
                        // A request for both modes keeps only data test
                        s_nxt.tagTest = cfgWdata[`CSTW_BIT_TAG_TEST]
                                        && !cfgWdata[`CSTW_BIT_DATA_TEST];
                    end
                    `CSTW_IDX_HOLD_LO: begin
                        s_nxt.holdWrLo = cfgWdata;
                    end
                    `CSTW_IDX_HOLD_HI: begin
                        s_nxt.holdWrHi = cfgWdata;
                    end
                    default: begin
                        // Other indexes belong to other blocks
                    end
                endcase
            end
        end

        // Hold reads return the captured tag, never the value written
        if (cfgRd) begin
            if (cfgPort == `CSTW_PORT_INDEX) begin
                s_nxt.cfgRdata = s_r.idx;
            end else begin
                unique case (s_r.idx)
                    `CSTW_IDX_TIMING: begin
                        s_nxt.cfgRdata = `CSTW_RST_BYTE;
                        s_nxt.cfgRdata[`CSTW_BIT_TAGWR_SLOW] = s_r.tagWrSlow;
                    end
                    `CSTW_IDX_CACHE: begin
                        s_nxt.cfgRdata = `CSTW_RST_BYTE;
                        s_nxt.cfgRdata[`CSTW_FLD_SIZE_HI:`CSTW_FLD_SIZE_LO] = s_r.cacheSize;
                        s_nxt.cfgRdata[`CSTW_BIT_DUAL_BANK] = s_r.dualBank;
                    end
                    `CSTW_IDX_TEST: begin
                        s_nxt.cfgRdata = `CSTW_RST_BYTE;
                        s_nxt.cfgRdata[`CSTW_BIT_WIN_HIGH] = s_r.winHigh;
                        s_nxt.cfgRdata[`CSTW_BIT_DATA_TEST] = s_r.dataTest;
                        s_nxt.cfgRdata[`CSTW_BIT_TAG_TEST] = s_r.tagTest;
                    end
                    `CSTW_IDX_HOLD_LO: begin
                        s_nxt.cfgRdata = s_r.holdRdLo;
                    end
                    `CSTW_IDX_HOLD_HI: begin
                        s_nxt.cfgRdata = s_r.holdRdHi;
                    end
                    default: begin
                        // Unclaimed index reads as zero
                        s_nxt.cfgRdata = `CSTW_RST_BYTE;
                    end
                endcase
            end
        end

        // Bus cycle sequencer
        unique case (s_r.st)
            cstw_pkg::CSTW_IDLE: begin
                if (busStart) begin
                    // Addresses go to the SRAMs mapped only for the 512K low window
                    s_nxt.sramAddr = s_r.testActive ? winSram : cpuAddr[19:2];
                    // Line address pin: plain A2 in single bank, size-selected in dual bank
                    s_nxt.ca2 = s_r.dualBank ? cpuAddr[ca2Sel] : cpuAddr[2];
                    s_nxt.uncache = s_r.testActive && !winHit;
                    if (s_r.testActive && winHit) begin
                        s_nxt.st = cstw_pkg::CSTW_ACCESS;
                        // Window decode stands in for tag compare
                        s_nxt.forceHit = 1'b1;
                        s_nxt.dramWrBlock = cpuWrite;
                        s_nxt.tagRead = s_r.tagTest && !cpuWrite;
                        if (s_r.dataTest) begin
                            // Data SRAM cycle at programmed hit timing
                            s_nxt.dataCsN = 1'b0;
                            s_nxt.dataWeN = !cpuWrite;
                            s_nxt.waitCnt = cpuWrite ? writeDirtyWs : readHitWs;
                            // Dual bank: A2 picks the upper dword bank; a missing bank floats
                            if (s_r.dualBank) begin
                                s_nxt.bankEnN = cpuAddr[2] ? 2'b01 : 2'b10;
                            end else begin
                                s_nxt.bankEnN = 2'b10;
                            end
                        end else if (cpuWrite) begin
                            // Tag write: holding value to tag at the line address
                            s_nxt.tagWeN = 1'b0;
                            s_nxt.waitCnt = s_r.tagWrSlow ? `CSTW_WS_TAGWR_SLOW
                                                          : `CSTW_WS_TAGWR_FAST;
                        end else begin
                            // Tag read completes with no wait states
                            s_nxt.waitCnt = `CSTW_WS_ZERO;
                        end
                    end
                end
            end
            cstw_pkg::CSTW_ACCESS: begin
                // Tag write enable is held for the whole data phase
                s_nxt.tagWeN = s_r.tagRead || !s_r.tagTest || !s_r.dramWrBlock;
                if (s_r.waitCnt == `CSTW_WS_ZERO) begin
                    // Tag sampled at the end of the first T2 of a read
                    if (s_r.tagRead) begin
                        s_nxt.holdRdLo = tagRdata[7:0];
                        s_nxt.holdRdHi = tagRdata[15:8];
                    end
                    // Non-burst ready closes every window cycle
                    s_nxt.rdyN = 1'b0;
                    s_nxt.tagWeN = 1'b1;
                    s_nxt.st = cstw_pkg::CSTW_IDLE;
                    s_nxt.forceHit = 1'b0;
                    s_nxt.dramWrBlock = 1'b0;
                    s_nxt.tagRead = 1'b0;
                    s_nxt.dataCsN = 1'b1;
                    s_nxt.dataWeN = 1'b1;
                    s_nxt.bankEnN = 2'b11;
                end else begin
                    s_nxt.waitCnt = s_r.waitCnt - 2'h1;
                end
            end
        endcase

        // Out-of-window flag drops with the modes, so it never outlives the inhibits
        if (!s_nxt.testActive) begin
            s_nxt.uncache = 1'b0;
        end

        // Data SRAMs never selected while tag test is on
        if (s_r.tagTest) begin
            s_nxt.dataCsN = 1'b1;
            s_nxt.dataWeN = 1'b1;
            s_nxt.bankEnN = 2'b11;
        end
    end

    // State register; both test modes come up off
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_r.st <= cstw_pkg::CSTW_IDLE;
            s_r.waitCnt <= `CSTW_WS_ZERO;
            s_r.tagRead <= 1'b0;
            s_r.idx <= `CSTW_RST_BYTE;
            s_r.tagWrSlow <= 1'b0;
            s_r.cacheSize <= `CSTW_RST_SIZE;
            s_r.dualBank <= 1'b0;
            s_r.winHigh <= 1'b0;
            s_r.dataTest <= 1'b0;
            s_r.tagTest <= 1'b0;
            s_r.holdWrLo <= `CSTW_RST_BYTE;
            s_r.holdWrHi <= `CSTW_RST_BYTE;
            s_r.holdRdLo <= `CSTW_RST_BYTE;
            s_r.holdRdHi <= `CSTW_RST_BYTE;
            s_r.cfgRdata <= `CSTW_RST_BYTE;
            s_r.rdyN <= 1'b1;
            s_r.forceHit <= 1'b0;
            s_r.dramWrBlock <= 1'b0;
            s_r.uncache <= 1'b0;
            s_r.testActive <= 1'b0;
            s_r.sramAddr <= '0;
            s_r.ca2 <= 1'b0;
            s_r.dataCsN <= 1'b1;
            s_r.dataWeN <= 1'b1;
            s_r.bankEnN <= 2'b11;
            s_r.tagWeN <= 1'b1;
            s_r.kenN <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign rdyN = s_r.rdyN;
    // Burst ready is never used by window cycles
    assign brdyN = s_r.st == s_r.st;
    assign kenN = s_r.kenN;
    assign cfgRdata = s_r.cfgRdata;
    assign forceHit = s_r.forceHit;
    assign dramWrBlock = s_r.dramWrBlock;
    assign cycUncacheable = s_r.uncache;
    // Any test mode stops fills, castouts and tag updates outside the window
    assign fillInhibit = s_r.testActive;
    assign castoutInhibit = s_r.testActive;
    assign tagUpdInhibit = s_r.testActive;
    assign sramAddr = s_r.sramAddr;
    assign cache_line_addr_bit2 = s_r.ca2;
    assign dataCsN = s_r.dataCsN;
    assign dataWeN = s_r.dataWeN;
    assign bankEnN = s_r.bankEnN;
    // One tag per 16-byte line: the low four address bits do not reach the tag
    assign tagAddr = s_r.sramAddr[19:4];
    assign tagWdata = {s_r.holdWrHi, s_r.holdWrLo};
    assign tagWeN = s_r.tagWeN;

endmodule // cstw_test_window
`default_nettype wire

// ---- cstw_test_window_monitor.sv ----
// Concurrent checks on the ports of the cache SRAM test window
`default_nettype none
module cstw_test_window_chk (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic rdyN,
    input wire logic brdyN,
    input wire logic kenNormalN,
    input wire logic kenN,
    input wire logic forceHit,
    input wire logic dramWrBlock,
    input wire logic cycUncacheable,
    input wire logic fillInhibit,
    input wire logic castoutInhibit,
    input wire logic tagUpdInhibit,
    input wire logic [19:2] sramAddr,
    input wire logic [19:4] tagAddr,
    input wire logic dataCsN,
    input wire logic dataWeN,
    input wire logic tagWeN
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // A window cycle opens with the forced hit rising
    sequence hitStart;
        $rose(forceHit);
    endsequence
    // Ready is low for one cycle only
    sequence rdyPulse;
        $fell(rdyN) ##1 rdyN;
    endsequence
    // Burst ready is never used by this block
    burst_never_a: assert property (brdyN) else $error("burst ready low");
    // Up to three programmed waits plus the fixed cycle
    hit_ready_a: assert property (hitStart |-> ##[1:4] rdyPulse)
        else $error("window cycle not readied in time");
    ready_cause_a: assert property ($fell(rdyN) |-> $past(forceHit))
        else $error("ready without forced hit");
    // Skip the first edge after reset, where the delayed copy was still held
    ken_follow_a: assert property ($past(rstn) |-> kenN == $past(kenNormalN))
        else $error("cache enable altered");
    write_block_a: assert property (dramWrBlock |-> forceHit)
        else $error("write block outside window");
    tag_data_off_a: assert property (!tagWeN |-> dataCsN && dataWeN)
        else $error("data SRAM active in tag cycle");
    data_hit_a: assert property (!dataCsN |-> forceHit)
        else $error("data SRAM select without hit");
    uncache_inh_a: assert property (cycUncacheable |-> fillInhibit && tagUpdInhibit)
        else $error("uncached cycle without inhibits");
    hit_inh_a: assert property (forceHit |-> fillInhibit && castoutInhibit)
        else $error("window hit without inhibits");
    tag_line_a: assert property (tagAddr == sramAddr[19:4])
        else $error("tag address not line address");
    tag_wr_wait_a: assert property ($fell(tagWeN) |-> ##[2:3] $fell(rdyN))
        else $error("tag write wait count");
endmodule // cstw_test_window_chk
bind cstw_test_window cstw_test_window_chk u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .rdyN(rdyN), .brdyN(brdyN),
    .kenNormalN(kenNormalN), .kenN(kenN), .forceHit(forceHit),
    .dramWrBlock(dramWrBlock), .cycUncacheable(cycUncacheable),
    .fillInhibit(fillInhibit), .castoutInhibit(castoutInhibit),
    .tagUpdInhibit(tagUpdInhibit), .sramAddr(sramAddr), .tagAddr(tagAddr),
    .dataCsN(dataCsN), .dataWeN(dataWeN), .tagWeN(tagWeN)
);
`default_nettype wire

// ---- cstw_window_dec.sv ----
// Test window decode and low-window address remap
`default_nettype none
`include "cstw_map.svh"

module cstw_window_dec (
    input wire logic [31:2] cpuAddr,
    input wire logic winHigh,
    input wire logic [2:0] cacheSize,
    output logic inWindow,
    output logic [19:2] sramAddr
);

    // Inclusive range check, used for each of the three windows
    function automatic logic inRange(input logic [31:2] a, input logic [31:0] lo,
                                     input logic [31:0] hi);
        inRange = (a >= lo[31:2]) && (a <= hi[31:2]);
    endfunction

    logic low512; // Full 512K window in the bottom megabyte

    // Window placement and size; size bits matter only for the low window
    always_comb begin
        low512 = !winHigh && (cacheSize == `CSTW_SIZE_512K);
        if (winHigh) begin
            inWindow = inRange(cpuAddr, `CSTW_WIN_HI_BASE, `CSTW_WIN_HI_TOP);
        end else if (low512) begin
            inWindow = inRange(cpuAddr, `CSTW_WIN_LO512_BASE, `CSTW_WIN_LO512_TOP);
        end else begin
            inWindow = inRange(cpuAddr, `CSTW_WIN_LO_BASE, `CSTW_WIN_LO_TOP);
        end
    end

    // Addresses pass straight through except the top 128K of the 512K low window
    always_comb begin
        sramAddr = cpuAddr[19:2];
        if (low512 && inRange(cpuAddr, `CSTW_REMAP_BASE, `CSTW_WIN_LO512_TOP)) begin
            sramAddr[`CSTW_REMAP_BIT] = 1'b0;
        end
    end

endmodule // cstw_window_dec
`default_nettype wire

// ---- tb_cache_sram_test_window.sv ----
// Self-checking testbench of the cache SRAM test window
`default_nettype none
`include "cstw_map.svh"
module tb_cache_sram_test_window;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rstn = 1'b0, adsN = 1'b1, cpuWrite = 1'b0, cpuMem = 1'b1;
    logic kenNormalN = 1'b1, cfgWr = 1'b0, cfgRd = 1'b0, cfgPort = 1'b0;
    logic [31:2] cpuAddr = '0;
    logic [1:0] readHitWs = 2'h1, writeDirtyWs = 2'h1;
    logic [7:0] cfgWdata = 8'h00;
    logic rdyN, brdyN, kenN, forceHit, dramWrBlock, cycUncacheable, lineBit2;
    logic fillInhibit, castoutInhibit, tagUpdInhibit, dataCsN, dataWeN, tagWeN;
    logic [7:0] cfgRdata;
    logic [1:0] bankEnN;
    logic [19:2] sramAddr;
    logic [19:4] tagAddr;
    logic [15:0] tagRdata, tagWdata;
    logic [2:0] strb; // Data select and bank enables seen during the last cycle
    int n_fail = 0, total_checks = 0;
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    // Toggling enable input, so its pass-through is exercised
    always @(negedge ref_clk) kenNormalN <= ~kenNormalN;
    cstw_test_window dut (
        .ref_clk(ref_clk), .rstn(rstn), .adsN(adsN), .cpuAddr(cpuAddr),
        .cpuWrite(cpuWrite), .cpuMem(cpuMem), .rdyN(rdyN), .brdyN(brdyN),
        .kenNormalN(kenNormalN), .readHitWs(readHitWs), .writeDirtyWs(writeDirtyWs),
        .kenN(kenN), .cfgWr(cfgWr), .cfgRd(cfgRd), .cfgPort(cfgPort),
        .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .forceHit(forceHit),
        .dramWrBlock(dramWrBlock), .cycUncacheable(cycUncacheable),
        .fillInhibit(fillInhibit), .castoutInhibit(castoutInhibit),
        .tagUpdInhibit(tagUpdInhibit), .sramAddr(sramAddr),
        .cache_line_addr_bit2(lineBit2), .dataCsN(dataCsN), .dataWeN(dataWeN),
        .bankEnN(bankEnN), .tagAddr(tagAddr), .tagRdata(tagRdata),
        .tagWdata(tagWdata), .tagWeN(tagWeN)
    );
    // Far side: the tag SRAM
    cstw_tag_sram_model tagRam (
        .ref_clk(ref_clk), .tagAddr(tagAddr), .tagWdata(tagWdata),
        .tagWeN(tagWeN), .tagRdata(tagRdata)
    );
    // Case equality, so an unknown never matches
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // Index write then data write on the port pair
    task automatic cfgW(input logic [7:0] idx, input logic [7:0] val);
        @(negedge ref_clk) {cfgWr, cfgPort, cfgWdata} = {1'b1, `CSTW_PORT_INDEX, idx};
        @(negedge ref_clk) {cfgPort, cfgWdata} = {`CSTW_PORT_DATA, val};
        @(negedge ref_clk) cfgWr = 1'b0;
    endtask
    // Read data is registered, valid the cycle after the strobe
    task automatic cfgR(input logic [7:0] idx, output logic [7:0] val);
        @(negedge ref_clk) {cfgWr, cfgPort, cfgWdata} = {1'b1, `CSTW_PORT_INDEX, idx};
        @(negedge ref_clk) {cfgWr, cfgRd, cfgPort} = {1'b0, 1'b1, `CSTW_PORT_DATA};
        @(negedge ref_clk) cfgRd = 1'b0;
        val = cfgRdata;
    endtask
    // One memory cycle; ws is -1 when the block never readies it
    task automatic busCyc(input logic [31:0] a, input logic wr, output int ws,
                          output logic [3:0] obs);
        @(negedge ref_clk) {adsN, cpuAddr, cpuWrite} = {1'b0, a[31:2], wr};
        @(negedge ref_clk) adsN = 1'b1;
        obs = {forceHit, dramWrBlock, dataWeN, tagWeN};
        strb = {dataCsN, bankEnN};
        ws = -1;
        // Ready lands N+2 falling edges after the strobe went low
        for (int m = 2; m < 10 && ws < 0; m++) begin
            @(negedge ref_clk);
            if (rdyN === 1'b0) ws = m - 2;
        end
    endtask
    // Placement and size decode at both edges of each window
    task automatic t_window();
        logic [43:0] tab [12] = '{44'h001_0004_0000, 44'h001_0007_FFFC,
            44'h000_0003_FFFC, 44'h000_0008_0000, 44'h031_0002_0000, 44'h031_0009_FFFC,
            44'h030_0001_FFFC, 44'h030_000A_0000, 44'h101_0010_0000, 44'h131_0017_FFFC,
            44'h100_0018_0000, 44'h100_0004_0000};
        int ws;
        logic [3:0] obs;
        foreach (tab[i]) begin
            cfgW(`CSTW_IDX_CACHE, {5'h0, tab[i][38:36]});
            // Cache mode bits live elsewhere and stay cleared throughout
            cfgW(`CSTW_IDX_TEST, {4'h0, tab[i][40], 3'h1});
            busCyc(tab[i][31:0], 1'b0, ws, obs);
            check(obs[3], tab[i][32], "window hit");
            check(ws, tab[i][32] ? 1 : -1, "read wait");
            check(cycUncacheable, !tab[i][32], "uncached");
        end
        check({fillInhibit, castoutInhibit, tagUpdInhibit}, 3'h7, "inhibits");
        $display("window decode test done");
    endtask
    // Remap of the 512K low window and line address bit choice
    task automatic t_remap();
        int ws;
        logic [3:0] obs;
        // The window test left the window high; the remap needs it low
        cfgW(`CSTW_IDX_TEST, 8'h01);
        cfgW(`CSTW_IDX_CACHE, {5'h0, `CSTW_SIZE_512K});
        busCyc(32'h0008_0010, 1'b0, ws, obs);
        check(sramAddr, 32'h0000_0004, "remapped top");
        busCyc(32'h0002_0010, 1'b0, ws, obs);
        check(sramAddr, 32'h0000_8004, "unchanged low");
        cfgW(`CSTW_IDX_TEST, 8'h09);
        busCyc(32'h0010_0010, 1'b0, ws, obs);
        check(sramAddr, 32'h0000_0004, "high unmapped");
        // 128K dual bank: the line bit follows A17, A2 picks the dword bank
        cfgW(`CSTW_IDX_CACHE, 8'h09);
        cfgW(`CSTW_IDX_TEST, 8'h01);
        busCyc(32'h0006_0000, 1'b0, ws, obs);
        check(lineBit2, 1'b1, "line bit set");
        check(strb, 3'h2, "low dword bank");
        busCyc(32'h0005_0004, 1'b0, ws, obs);
        check(lineBit2, 1'b0, "line bit clear");
        check(strb, 3'h1, "upper dword bank");
        $display("remap test done");
    endtask
    // Programmed hit timing for reads and dirty-hit timing for writes
    task automatic t_data();
        int ws;
        logic [3:0] obs;
        cfgW(`CSTW_IDX_CACHE, 8'h00);
        {readHitWs, writeDirtyWs} = {2'h2, 2'h3};
        busCyc(32'h0004_0020, 1'b0, ws, obs);
        check(ws, 2, "read timing");
        check(obs, 4'hB, "read strobes");
        check(strb, 3'h2, "data select");
        busCyc(32'h0004_0024, 1'b1, ws, obs);
        check(ws, 3, "write timing");
        check(obs, 4'hD, "write strobes");
        $display("data timing test done");
    endtask
    // Tag write through the holds, then capture on a window read of the same line
    task automatic t_tag();
        int ws;
        logic [3:0] obs;
        logic [7:0] v;
        cfgW(`CSTW_IDX_TEST, 8'h02);
        cfgW(`CSTW_IDX_TIMING, 8'h00);
        cfgW(`CSTW_IDX_HOLD_LO, 8'hA5);
        cfgW(`CSTW_IDX_HOLD_HI, 8'h3C);
        cfgR(`CSTW_IDX_HOLD_LO, v);
        check(v, 8'h00, "hold not echoed");
        busCyc(32'h0004_0010, 1'b1, ws, obs);
        check(ws, 1, "fast tag write");
        check(obs, 4'hE, "tag write strobes");
        check(tagWdata, 16'h3CA5, "tag data");
        cfgW(`CSTW_IDX_TIMING, 8'h01);
        busCyc(32'h0004_0020, 1'b1, ws, obs);
        check(ws, 2, "slow tag write");
        busCyc(32'h0004_001C, 1'b0, ws, obs);
        check(ws, 0, "tag read wait");
        check(obs, 4'hB, "tag read strobes");
        check(strb, 3'h7, "data SRAM off");
        cfgR(`CSTW_IDX_HOLD_LO, v);
        check(v, 8'hA5, "captured low");
        cfgR(`CSTW_IDX_HOLD_HI, v);
        check(v, 8'h3C, "captured high");
        $display("tag test done");
    endtask
    // Sizing pass at 1M with dual bank: sizes tried from 1M downward
    task automatic t_size();
        int ws;
        logic [3:0] obs;
        cfgW(`CSTW_IDX_TEST, 8'h09);
        for (int s = 4; s > 0; s--) begin
            cfgW(`CSTW_IDX_CACHE, {5'h01, 3'(s)});
            busCyc(32'h0017_0000, 1'b0, ws, obs);
            check(obs[3], 1'b1, "high window any size");
            check(lineBit2, s != 3, "sized line bit");
        end
        $display("sizing test done");
    endtask
    // Both modes requested keeps only data test; modes off end window hits
    task automatic t_modes();
        int ws;
        logic [3:0] obs;
        logic [7:0] v;
        cfgW(`CSTW_IDX_TEST, 8'h03);
        cfgR(`CSTW_IDX_TEST, v);
        check(v, 8'h01, "single mode");
        cfgW(`CSTW_IDX_TEST, 8'h00);
        busCyc(32'h0004_0000, 1'b0, ws, obs);
        check(obs[3], 1'b0, "no test no hit");
        check(ws, -1, "no test no ready");
        $display("mode test done");
    endtask
    // Prints counts and the verdict, then ends the run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence after 20 cycles of reset
    initial begin
        repeat (20) @(negedge ref_clk);
        rstn = 1'b1;
        check({rdyN, forceHit, fillInhibit, cfgRdata}, 11'h400, "reset state");
        t_window();
        t_remap();
        t_data();
        t_tag();
        t_size();
        t_modes();
        finish_test();
    end
    // Watchdog: the tests need a few thousand cycles at most
    initial begin
        #100us;
        n_fail++;
        finish_test();
    end
endmodule // tb_cache_sram_test_window
`default_nettype wire
